// ### dcir_pkg.sv
// Shared constants and types for the line interface control and interrupt registers
package dcir_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int WDOG_WINDOW_MS = 4096;
	localparam int WDOG_CYCLES = WDOG_WINDOW_MS * CYC_PER_MS;
	localparam int KEEP_MS = 2048;
	localparam int KEEP_CYCLES = KEEP_MS * CYC_PER_MS;

	localparam int REG_AW = 8;
	localparam int REG_DW = 8;
	localparam int LOOP_CUR_W = 5;
	localparam logic [LOOP_CUR_W-1:0] LOOP_CUR_MAX = 5'h1f;

	localparam logic [REG_AW-1:0] ADDR_CONTROL_TWO = 8'h02;
	localparam logic [REG_AW-1:0] ADDR_IRQ_MASK = 8'h03;
	localparam logic [REG_AW-1:0] ADDR_IRQ_FLAGS = 8'h04;

	localparam int CTL_WDOG_BIT = 4;
	localparam int CTL_ALOOP_BIT = 3;
	localparam int CTL_RMODE_BIT = 2;
	localparam int CTL_HYB_BIT = 1;
	localparam int CTL_RX_BIT = 0;
	localparam logic [REG_DW-1:0] CTL_RESET = 8'h03;
	localparam logic [REG_DW-1:0] CTL_WMASK = 8'h1f;

	localparam int IRQ_RING_BIT = 7;
	localparam int IRQ_FRAME_BIT = 5;
	localparam int IRQ_DROP_BIT = 3;
	localparam int IRQ_LOOP_BIT = 2;
	localparam logic [REG_DW-1:0] IRQ_WMASK = 8'hac;
	localparam logic [REG_DW-1:0] MASK_RESET = 8'h00;
	localparam logic [REG_DW-1:0] FLAG_RESET = 8'h00;
	localparam logic [REG_DW-1:0] ALL_ONES = 8'hff;

	localparam int AVS_AW = 4;
	localparam int AVS_DW = 32;
	localparam logic [AVS_AW-1:0] HOST_OFS_CMD = 4'h0;
	localparam logic [AVS_AW-1:0] HOST_OFS_STATUS = 4'h4;
	localparam logic [AVS_AW-1:0] HOST_OFS_KEEP = 4'h8;
	localparam int CMD_DATA_LSB = 0;
	localparam int CMD_ADDR_LSB = 8;
	localparam int CMD_WR_BIT = 16;
	localparam int STS_BUSY_BIT = 8;
	localparam int STS_IRQ_BIT = 9;
	localparam int KEEP_EN_BIT = 0;

	typedef enum logic [0:0] {
		st_idle = 1'b0,
		st_req = 1'b1
	} dcir_link_t;
endpackage

// ### dcir_if.sv
// Register access link between the host controller and the line interface device
`timescale 1ns/1ns
interface dcir_if;
	import dcir_pkg::*;
	logic req;
	logic wr;
	logic [REG_AW-1:0] addr;
	logic [REG_DW-1:0] wdata;
	logic ack;
	logic [REG_DW-1:0] rdata;
	logic irq;

	modport device (
		input req,
		input wr,
		input addr,
		input wdata,
		output ack,
		output rdata,
		output irq
	);
	modport host (
		output req,
		output wr,
		output addr,
		output wdata,
		input ack,
		input rdata,
		input irq
	);
endinterface

// ### dcir_sync.sv
// Two-stage synchroniser for a group of asynchronous levels
`timescale 1ns/1ns
module dcir_sync #(
	parameter int W = 1
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= i_async;
			sync_ff <= meta_ff;
		end
	end

	assign o_sync = sync_ff;
endmodule

// ### dcir_device.sv
// Device end: control, mask and flag registers with write watchdog
`timescale 1ns/1ns
// Functional notes
// - Watchdog enable sticks until hardware reset
// - Watchdog expiry forces line on-hook
// - Only register writes restart watchdog
// - Analog loop bit drives loopback
// - Ring mode selects positive or both thresholds
// - Hybrid bit connects hybrid to transmit
// - Receive bit enables receive path
// - Ring mask gates ring interrupt
// - Frame mask gates frame-loss interrupt
// - Dropout mask gates dropout interrupt
// - Overload mask gates overload interrupt
// - Ring flag sticky, cleared by zero
// - Frame flag set on lock loss
// - Dropout flag shows line power lost
// - Overload flag set at current maximum
// - Reserved bits written zero, read ignored
module dcir_device import dcir_pkg::*; #(
	parameter int WDOG_CYC = WDOG_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_rst,
	dcir_if.device bus,
	input wire logic i_ring_pos,
	input wire logic i_ring_neg,
	input wire logic i_frame_lost,
	input wire logic i_supply_dropout,
	input wire logic [LOOP_CUR_W-1:0] i_loop_current,
	output logic o_force_on_hook,
	output logic o_analog_loop,
	output logic o_hybrid_connect,
	output logic o_receive_path_enable,
	output logic o_ring_detect
);
	localparam int WDW = $clog2(WDOG_CYC + 1);
	localparam int SW = LOOP_CUR_W + 4;

	logic [SW-1:0] line_sync;
	logic ring_pos_s;
	logic ring_neg_s;
	logic frame_lost_s;
	logic dropout_s;
	logic [LOOP_CUR_W-1:0] loop_current_s;

	logic ack_ff;
	logic [REG_DW-1:0] rdata_ff;
	logic irq_ff;
	logic write_watchdog_enable_ff;
	logic analog_loop_enable_ff;
	logic ring_polarity_mode_ff;
	logic hybrid_connect_ff;
	logic receive_path_enable_ff;
	logic [REG_DW-1:0] mask_ff;
	logic [REG_DW-1:0] flags_ff;
	logic [REG_DW-1:0] nxt_flags;
	logic [WDW-1:0] wdog_cnt_ff;
	logic force_on_hook_ff;
	logic ring_prev_ff;
	logic frame_prev_ff;
	logic ring_detect_ff;

	logic take;
	logic do_wr;
	logic reg_wr;
	logic ring_now;
	logic [REG_DW-1:0] flag_set;
	logic [REG_DW-1:0] flag_keep;
	logic [REG_DW-1:0] ctl_read;

	dcir_sync #(
		.W(SW)
	) u_line_sync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_async({i_ring_pos, i_ring_neg, i_frame_lost, i_supply_dropout, i_loop_current}),
		.o_sync(line_sync)
	);

	assign {ring_pos_s, ring_neg_s, frame_lost_s, dropout_s, loop_current_s} = line_sync;

	// Each request is taken once; the host drops req on the edge that sees ack
	assign take = bus.req && !ack_ff;
	assign do_wr = take && bus.wr;
	assign reg_wr = do_wr && (bus.addr == ADDR_CONTROL_TWO || bus.addr == ADDR_IRQ_MASK ||
		bus.addr == ADDR_IRQ_FLAGS);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= take;
		end
	end

	assign ctl_read = {3'b000, write_watchdog_enable_ff, analog_loop_enable_ff,
		ring_polarity_mode_ff, hybrid_connect_ff, receive_path_enable_ff};

	// Reserved bits read as zero
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rdata_ff <= '0;
		end else if (take && !bus.wr) begin
			case (bus.addr)
				ADDR_CONTROL_TWO: rdata_ff <= ctl_read & CTL_WMASK;
				ADDR_IRQ_MASK: rdata_ff <= mask_ff;
				ADDR_IRQ_FLAGS: rdata_ff <= flags_ff;
				default: rdata_ff <= '0;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			analog_loop_enable_ff <= CTL_RESET[CTL_ALOOP_BIT];
			ring_polarity_mode_ff <= CTL_RESET[CTL_RMODE_BIT];
			hybrid_connect_ff <= CTL_RESET[CTL_HYB_BIT];
			receive_path_enable_ff <= CTL_RESET[CTL_RX_BIT];
		end else if (do_wr && bus.addr == ADDR_CONTROL_TWO) begin
			analog_loop_enable_ff <= bus.wdata[CTL_ALOOP_BIT];
			ring_polarity_mode_ff <= bus.wdata[CTL_RMODE_BIT];
			hybrid_connect_ff <= bus.wdata[CTL_HYB_BIT];
			receive_path_enable_ff <= bus.wdata[CTL_RX_BIT];
		end
	end

	// Once set only reset clears it; written zeros are ignored
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			write_watchdog_enable_ff <= CTL_RESET[CTL_WDOG_BIT];
		end else if (do_wr && bus.addr == ADDR_CONTROL_TWO && bus.wdata[CTL_WDOG_BIT]) begin
			write_watchdog_enable_ff <= 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wdog_cnt_ff <= '0;
			force_on_hook_ff <= 1'b0;
		end else if (reg_wr) begin
			wdog_cnt_ff <= '0;
			force_on_hook_ff <= 1'b0;
		end else if (write_watchdog_enable_ff) begin
			if (wdog_cnt_ff == WDW'(WDOG_CYC - 1)) begin
				force_on_hook_ff <= 1'b1;
			end else begin
				wdog_cnt_ff <= wdog_cnt_ff + 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			mask_ff <= MASK_RESET;
		end else if (do_wr && bus.addr == ADDR_IRQ_MASK) begin
			mask_ff <= bus.wdata & IRQ_WMASK;
		end
	end

	assign ring_now = ring_pos_s || (ring_polarity_mode_ff && ring_neg_s);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ring_prev_ff <= 1'b0;
			frame_prev_ff <= 1'b0;
			ring_detect_ff <= 1'b0;
		end else begin
			ring_prev_ff <= ring_now;
			frame_prev_ff <= frame_lost_s;
			ring_detect_ff <= ring_now;
		end
	end

	// Hardware set wins over a software clear in the same cycle
	always_comb begin
		flag_set = '0;
		flag_set[IRQ_RING_BIT] = ring_now && !ring_prev_ff;
		flag_set[IRQ_FRAME_BIT] = frame_lost_s && !frame_prev_ff;
		flag_set[IRQ_DROP_BIT] = dropout_s;
		flag_set[IRQ_LOOP_BIT] = loop_current_s == LOOP_CUR_MAX;
		flag_keep = (do_wr && bus.addr == ADDR_IRQ_FLAGS) ? bus.wdata : ALL_ONES;
		nxt_flags = ((flags_ff & flag_keep) | flag_set) & IRQ_WMASK;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			flags_ff <= FLAG_RESET;
		end else begin
			flags_ff <= nxt_flags;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(flags_ff & mask_ff);
		end
	end

	assign bus.ack = ack_ff;
	assign bus.rdata = rdata_ff;
	assign bus.irq = irq_ff;
	assign o_force_on_hook = force_on_hook_ff;
	assign o_analog_loop = analog_loop_enable_ff;
	assign o_hybrid_connect = hybrid_connect_ff;
	assign o_receive_path_enable = receive_path_enable_ff;
	assign o_ring_detect = ring_detect_ff;
endmodule

// ### dcir_host.sv
// Host end: Avalon-MM command registers driving the register link
`timescale 1ns/1ns
module dcir_host import dcir_pkg::*; #(
	parameter int KEEP_CYC = KEEP_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_rst,
	dcir_if.host bus,
	input wire logic [AVS_AW-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [AVS_DW-1:0] i_avs_writedata,
	output logic [AVS_DW-1:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output logic o_irq
);
	localparam int KW = $clog2(KEEP_CYC + 1);

	dcir_link_t state_ff;
	logic waitreq_ff;
	logic [AVS_DW-1:0] readdata_ff;
	logic req_ff;
	logic wr_ff;
	logic [REG_AW-1:0] addr_ff;
	logic [REG_DW-1:0] wdata_ff;
	logic [REG_DW-1:0] rdata_ff;
	logic [REG_DW-1:0] shadow_mask_ff;
	logic keep_en_ff;
	logic [KW-1:0] keep_cnt_ff;
	logic irq_ff;

	logic busy;
	logic accept;
	logic cmd_done;
	logic keep_due;
	logic [REG_AW-1:0] cmd_addr;
	logic [REG_DW-1:0] cmd_data;

	function automatic logic [REG_DW-1:0] wmask(input logic [REG_AW-1:0] a);
		case (a)
			ADDR_CONTROL_TWO: wmask = CTL_WMASK;
			ADDR_IRQ_MASK: wmask = IRQ_WMASK;
			ADDR_IRQ_FLAGS: wmask = IRQ_WMASK;
			default: wmask = ALL_ONES;
		endcase
	endfunction

	assign busy = state_ff != st_idle;
	assign accept = (i_avs_read || i_avs_write) && waitreq_ff &&
		!(i_avs_write && i_avs_address == HOST_OFS_CMD && busy);
	assign cmd_done = i_avs_write && !waitreq_ff && i_avs_address == HOST_OFS_CMD;
	// A command write being accepted outranks the keepalive, or it would be lost
	assign keep_due = keep_en_ff && !busy && waitreq_ff && keep_cnt_ff == KW'(KEEP_CYC - 1) &&
		!(i_avs_write && i_avs_address == HOST_OFS_CMD);
	assign cmd_addr = i_avs_writedata[CMD_ADDR_LSB +: REG_AW];
	// Reserved bits always go out as zero
	assign cmd_data = i_avs_writedata[CMD_DATA_LSB +: REG_DW] & wmask(cmd_addr);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			waitreq_ff <= 1'b1;
			readdata_ff <= '0;
		end else if (accept) begin
			waitreq_ff <= 1'b0;
			case (i_avs_address)
				HOST_OFS_STATUS: readdata_ff <= {22'h00_0000, irq_ff, busy, rdata_ff};
				HOST_OFS_KEEP: readdata_ff <= {31'h0000_0000, keep_en_ff};
				default: readdata_ff <= '0;
			endcase
		end else begin
			waitreq_ff <= 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			keep_en_ff <= 1'b0;
		end else if (i_avs_write && !waitreq_ff && i_avs_address == HOST_OFS_KEEP) begin
			keep_en_ff <= i_avs_writedata[KEEP_EN_BIT];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_ff <= st_idle;
			req_ff <= 1'b0;
			wr_ff <= 1'b0;
			addr_ff <= '0;
			wdata_ff <= '0;
		end else begin
			case (state_ff)
				st_idle: begin
					if (cmd_done) begin
						state_ff <= st_req;
						req_ff <= 1'b1;
						wr_ff <= i_avs_writedata[CMD_WR_BIT];
						addr_ff <= cmd_addr;
						wdata_ff <= cmd_data;
					end else if (keep_due) begin
						// Rewrite the mask to keep the line off-hook
						state_ff <= st_req;
						req_ff <= 1'b1;
						wr_ff <= 1'b1;
						addr_ff <= ADDR_IRQ_MASK;
						wdata_ff <= shadow_mask_ff;
					end
				end
				st_req: begin
					if (bus.ack) begin
						state_ff <= st_idle;
						req_ff <= 1'b0;
					end
				end
				default: begin
					state_ff <= st_idle;
					req_ff <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rdata_ff <= '0;
		end else if (state_ff == st_req && bus.ack && !wr_ff) begin
			rdata_ff <= bus.rdata;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			shadow_mask_ff <= MASK_RESET;
		end else if (state_ff == st_idle && cmd_done && i_avs_writedata[CMD_WR_BIT] &&
			cmd_addr == ADDR_IRQ_MASK) begin
			shadow_mask_ff <= cmd_data;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			keep_cnt_ff <= '0;
		end else if (!keep_en_ff || (state_ff == st_req && bus.ack && wr_ff)) begin
			keep_cnt_ff <= '0;
		end else if (keep_cnt_ff != KW'(KEEP_CYC - 1)) begin
			keep_cnt_ff <= keep_cnt_ff + 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= bus.irq;
		end
	end

	assign bus.req = req_ff;
	assign bus.wr = wr_ff;
	assign bus.addr = addr_ff;
	assign bus.wdata = wdata_ff;
	assign o_avs_readdata = readdata_ff;
	assign o_avs_waitrequest = waitreq_ff;
	assign o_irq = irq_ff;
endmodule

// ### dcir_asserts.sv
// Protocol and register readback checks on the register link
`timescale 1ns/1ns
module dcir_asserts import dcir_pkg::*; (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic req,
	input wire logic wr,
	input wire logic [REG_AW-1:0] addr,
	input wire logic [REG_DW-1:0] wdata,
	input wire logic ack,
	input wire logic [REG_DW-1:0] rdata,
	input wire logic irq
);
	logic [REG_DW-1:0] ctl_ff;
	logic [REG_DW-1:0] mask_ff;
	logic take;
	logic rd_ack;
	assign take = req && !ack && wr;
	assign rd_ack = ack && !wr;
	// Enable bit only ever sets, so it is kept from the old value
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ctl_ff <= CTL_RESET;
		end else if (take && addr == ADDR_CONTROL_TWO) begin
			ctl_ff <= (wdata & CTL_WMASK) | (ctl_ff & 8'h10);
		end
	end
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			mask_ff <= MASK_RESET;
		end else if (take && addr == ADDR_IRQ_MASK) begin
			mask_ff <= wdata & IRQ_WMASK;
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	property p_ack_next; req && !ack |=> ack; endproperty
	a_ack_next: assert property (p_ack_next)
		else $error("ack late");
	property p_ack_once; ack |=> !ack; endproperty
	a_ack_once: assert property (p_ack_once)
		else $error("ack too long");
	property p_req_hold;
		req && !ack |=> req && $stable(addr) && $stable(wr) && $stable(wdata);
	endproperty
	a_req_hold: assert property (p_req_hold)
		else $error("request changed");
	property p_wd_sticky;
		rd_ack && addr == ADDR_CONTROL_TWO |-> rdata[CTL_WDOG_BIT] == ctl_ff[CTL_WDOG_BIT];
	endproperty
	a_wd_sticky: assert property (p_wd_sticky)
		else $error("watchdog enable wrong");
	property p_ctl_read;
		rd_ack && addr == ADDR_CONTROL_TWO |-> rdata[3:0] == ctl_ff[3:0] && rdata[7:5] == 3'h0;
	endproperty
	a_ctl_read: assert property (p_ctl_read)
		else $error("control readback wrong");
	property p_mask_read; rd_ack && addr == ADDR_IRQ_MASK |-> rdata == mask_ff; endproperty
	a_mask_read: assert property (p_mask_read)
		else $error("mask readback wrong");
	property p_unmapped;
		rd_ack && (addr < ADDR_CONTROL_TWO || addr > ADDR_IRQ_FLAGS) |-> rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	property p_irq_mask; irq |-> $past(mask_ff) != 8'h00; endproperty
	a_irq_mask: assert property (p_irq_mask)
		else $error("irq without mask");
endmodule

// ### daa_control_interrupt_regs_test.sv
// Bench joining host and device ends over the register link
`timescale 1ns/1ns
module daa_control_interrupt_regs_test;
	import dcir_pkg::*;
	localparam int WD = 50;
	logic i_clk = 0;
	logic i_rst = 1;
	logic [3:0] a_addr = '0;
	logic a_rd = 0;
	logic a_wr = 0;
	logic [31:0] a_wd = '0;
	logic [31:0] a_q;
	logic a_wait, o_irq, neg = 0;
	logic [3:0] src = '0;
	logic f_hook, f_loop, f_hyb, f_rx, f_ring;
	int errors = 0;
	int compares = 0;
	int cyc = 0;
	always #5 i_clk = ~i_clk;
	dcir_if u_dcir_if ();
	dcir_host #(.KEEP_CYC(20)) u_dcir_host (.i_clk(i_clk), .i_rst(i_rst), .bus(u_dcir_if),
		.i_avs_address(a_addr), .i_avs_read(a_rd), .i_avs_write(a_wr),
		.i_avs_writedata(a_wd), .o_avs_readdata(a_q), .o_avs_waitrequest(a_wait),
		.o_irq(o_irq));
	dcir_device #(.WDOG_CYC(WD)) u_dcir_device (.i_clk(i_clk), .i_rst(i_rst), .bus(u_dcir_if),
		.i_ring_pos(src[0]), .i_ring_neg(neg), .i_frame_lost(src[1]),
		.i_supply_dropout(src[2]), .i_loop_current({5{src[3]}}), .o_force_on_hook(f_hook),
		.o_analog_loop(f_loop), .o_hybrid_connect(f_hyb), .o_receive_path_enable(f_rx),
		.o_ring_detect(f_ring));
	dcir_asserts u_dcir_asserts (.i_clk(i_clk), .i_rst(i_rst), .req(u_dcir_if.req),
		.wr(u_dcir_if.wr), .addr(u_dcir_if.addr), .wdata(u_dcir_if.wdata),
		.ack(u_dcir_if.ack), .rdata(u_dcir_if.rdata), .irq(u_dcir_if.irq));
	task automatic summarize();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			summarize();
		end
	end
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic avs(input logic [3:0] ad, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge i_clk);
		a_addr <= ad;
		a_wr <= w;
		a_rd <= !w;
		a_wd <= d;
		// Flop outputs still show the values that this edge samples
		do @(posedge i_clk); while (a_wait !== 1'b0);
		q = a_q;
		a_rd <= 0;
		a_wr <= 0;
	endtask
	task automatic link(input logic w, input logic [7:0] ad, input logic [7:0] d,
		output logic [7:0] q);
		logic [31:0] r;
		avs(HOST_OFS_CMD, 1, {15'h0000, w, ad, d}, r);
		repeat (20) begin
			avs(HOST_OFS_STATUS, 0, '0, r);
			if (r[STS_BUSY_BIT] === 1'b0) break;
		end
		cmp("busy", 0, r[STS_BUSY_BIT]);
		q = r[7:0];
	endtask
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		logic [7:0] q;
		link(1, ad, d, q);
	endtask
	task automatic rd_chk(input string n, input logic [7:0] ad, input logic [7:0] e);
		logic [7:0] q;
		link(0, ad, 8'h00, q);
		cmp(n, e, q);
	endtask
	task automatic t_ctrl();
		logic [7:0] v[4] = '{8'h0a, 8'h05, 8'h0f, 8'h00};
		logic [31:0] r;
		rd_chk("control_two", ADDR_CONTROL_TWO, CTL_RESET);
		rd_chk("unmapped", 8'h05, 8'h00);
		avs(4'hc, 0, '0, r);
		cmp("avs unmapped", '0, r);
		foreach (v[i]) begin
			wr(ADDR_CONTROL_TWO, v[i]);
			rd_chk("control_two", ADDR_CONTROL_TWO, v[i]);
			cmp("outputs", {v[i][3], v[i][1], v[i][0]}, {f_loop, f_hyb, f_rx});
		end
		neg <= 1;
		repeat (6) @(posedge i_clk);
		cmp("ring mode0", 0, f_ring);
		wr(ADDR_CONTROL_TWO, 8'h04);
		cmp("ring mode1", 1, f_ring);
		neg <= 0;
	endtask
	task automatic t_irq();
		int b[4] = '{IRQ_RING_BIT, IRQ_FRAME_BIT, IRQ_DROP_BIT, IRQ_LOOP_BIT};
		logic [7:0] m;
		wr(ADDR_CONTROL_TWO, 8'h03);
		for (int k = 0; k < 4; k++) begin
			m = 8'h01 << b[k];
			wr(ADDR_IRQ_MASK, 8'h00);
			wr(ADDR_IRQ_FLAGS, 8'h00);
			src[k] <= 1;
			repeat (8) @(posedge i_clk);
			cmp("irq masked", 0, o_irq);
			rd_chk("flag set", ADDR_IRQ_FLAGS, m);
			wr(ADDR_IRQ_MASK, m);
			wr(ADDR_IRQ_FLAGS, m);
			rd_chk("flag kept", ADDR_IRQ_FLAGS, m);
			cmp("irq", 1, o_irq);
			src[k] <= 0;
			repeat (8) @(posedge i_clk);
			wr(ADDR_IRQ_FLAGS, 8'h00);
			rd_chk("flag clear", ADDR_IRQ_FLAGS, 8'h00);
			cmp("irq clear", 0, o_irq);
		end
	endtask
	task automatic t_wdog();
		logic [31:0] r;
		repeat (WD + 20) @(posedge i_clk);
		cmp("hook off", 0, f_hook);
		wr(ADDR_CONTROL_TWO, 8'h13);
		wr(ADDR_CONTROL_TWO, 8'h03);
		repeat (WD - 20) @(posedge i_clk);
		cmp("hook early", 0, f_hook);
		repeat (30) @(posedge i_clk);
		cmp("hook", 1, f_hook);
		rd_chk("sticky", ADDR_CONTROL_TWO, 8'h13);
		cmp("hook read", 1, f_hook);
		wr(ADDR_IRQ_MASK, 8'h00);
		cmp("hook write", 0, f_hook);
		avs(HOST_OFS_KEEP, 1, 32'h0000_0001, r);
		repeat (3 * WD) @(posedge i_clk);
		cmp("keepalive", 0, f_hook);
		repeat (6) rd_chk("keep cmd", ADDR_CONTROL_TWO, 8'h13);
		cmp("keep cmd hook", 0, f_hook);
		i_rst <= 1;
		repeat (8) @(posedge i_clk);
		i_rst <= 0;
		rd_chk("after reset", ADDR_CONTROL_TWO, CTL_RESET);
	endtask
	initial begin
		repeat (8) @(posedge i_clk);
		i_rst <= 0;
		t_ctrl();
		t_irq();
		t_wdog();
		summarize();
	end
endmodule
